// *** pkg/pflt_pkg.sv ***
// constants shared by the port foldback limit timer design
//------------------------------------------------------------------
//------------------------------------------------------------------
package pflt_pkg;
  localparam int NPORTS = 4;
  localparam int TMR_W = 8;
  // timing
  localparam int CLK_MHZ = 50;
  localparam int TICK_US = 10;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam int TICK_W = 9;
  localparam int UP_DIV = 4; // count-up runs at a quarter of the down rate
  localparam logic [1:0] UP_DIV_LAST = 2'h3;
  // timeout setting to full count, in ticks
  localparam logic [TMR_W-1:0] LIMIT_TIMEOUT_SETTING_MAX0 = 8'h3C;
  localparam logic [TMR_W-1:0] LIMIT_TIMEOUT_SETTING_MAX1 = 8'h0F;
  localparam logic [TMR_W-1:0] LIMIT_TIMEOUT_SETTING_MAX2 = 8'h1E;
  localparam logic [TMR_W-1:0] LIMIT_TIMEOUT_SETTING_MAX3 = 8'h78;
  localparam logic [TMR_W-1:0] TMR_ZERO = 8'h00;
  localparam logic [TMR_W-1:0] TMR_ONE = 8'h01;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CURVE = 8'h04;
  localparam logic [7:0] OFS_TIMING = 8'h08;
  localparam logic [7:0] OFS_CUTCFG = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_EVENT = 8'h14;
  localparam logic [7:0] OFS_MASK = 8'h18;
  localparam logic [7:0] OFS_TMRVAL = 8'h1C;
  // control fields
  localparam int CTRL_AUTO_BIT = 4;
  localparam int CTRL_ALT_SENSE_BIT = 5;
  localparam int CUT_W = 3;
  // auto mode encodings of the cut threshold and of the class result
  localparam logic [2:0] CUT_TYPE1 = 3'h0;
  localparam logic [2:0] CUT_TYPE2 = 3'h6;
  localparam logic [2:0] CLASS_TYPE2 = 3'h4;
  // reset values
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [3:0] CURVE_RST = 4'h0;
  localparam logic [1:0] TIMING_RST = 2'h0;
  localparam logic [11:0] CUTCFG_RST = 12'h000;
  localparam logic [3:0] EVENT_RST = 4'h0;
  localparam logic [3:0] MASK_RST = 4'h0;
endpackage : pflt_pkg

// *** pkg/pflt_timer_if.sv ***
// signals between the port supervisor and one limit timer
`timescale 1ns/100ps
interface pflt_timer_if;
  logic tick;
  logic turn_on;
  logic powered;
  logic limit;
  logic [1:0] setting;
  logic [pflt_pkg::TMR_W-1:0] count;
  logic expire;
  modport ctrl (output tick, output turn_on, output powered,
                output limit, output setting, input count, input expire);
  modport tmr (input tick, input turn_on, input powered,
               input limit, input setting, output count, output expire);
endinterface : pflt_timer_if

// *** core/pflt_sync.sv ***
// three stage synchroniser with agreement filter for pin inputs
`timescale 1ns/100ps
module pflt_sync #(
  parameter int W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] s1_q, s2_q, s3_q, out_q;
  logic [W-1:0] out_d;

  // a bit changes only once stages two and three agree
  generate
    for (genvar i = 0; i < W; i++) begin : g_bit
      always_comb begin
        out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign sync_out = out_q;
endmodule : pflt_sync

// *** core/pflt_limit_timer.sv ***
// per-port up/down limit timer with saturation and expiry pulse
`timescale 1ns/100ps
module pflt_limit_timer (
  input wire logic pclk,
  input wire logic presetn,
  pflt_timer_if.tmr tif
);
  logic [pflt_pkg::TMR_W-1:0] cnt_q, cnt_d, max_cnt;
  logic [1:0] up_q, up_d;
  logic exp_q, exp_d;

  // full count chosen by the timeout setting
  always_comb begin
    case (tif.setting)
      2'h0: max_cnt = pflt_pkg::LIMIT_TIMEOUT_SETTING_MAX0;
      2'h1: max_cnt = pflt_pkg::LIMIT_TIMEOUT_SETTING_MAX1;
      2'h2: max_cnt = pflt_pkg::LIMIT_TIMEOUT_SETTING_MAX2;
      default: max_cnt = pflt_pkg::LIMIT_TIMEOUT_SETTING_MAX3;
    endcase
  end

  // down on limit, slow up otherwise; a setting change also clamps
  always_comb begin
    cnt_d = cnt_q;
    up_d = up_q;
    exp_d = 1'b0;
    if (tif.turn_on || !tif.powered) begin
      cnt_d = max_cnt;
      up_d = 2'h0;
    end else if (tif.tick) begin
      if (tif.limit) begin
        up_d = 2'h0;
        if (cnt_q <= pflt_pkg::TMR_ONE) begin
          cnt_d = pflt_pkg::TMR_ZERO;
          exp_d = 1'b1;
        end else begin
          cnt_d = cnt_q - pflt_pkg::TMR_ONE;
        end
      end else begin
        up_d = 2'(up_q + 2'h1);
        if (cnt_q >= max_cnt) begin
          cnt_d = max_cnt;
        end else if (up_q == pflt_pkg::UP_DIV_LAST) begin
          cnt_d = cnt_q + pflt_pkg::TMR_ONE;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= pflt_pkg::LIMIT_TIMEOUT_SETTING_MAX0;
      up_q <= 2'h0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      up_q <= up_d;
      exp_q <= exp_d;
    end
  end

  assign tif.count = cnt_q;
  assign tif.expire = exp_q;
endmodule : pflt_limit_timer

// *** core/pflt_top.sv ***
// four-port foldback supervision with limit timers and apb registers
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/100ps
module pflt_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] limit_cmp,
  input wire logic [3:0] power_good,
  input wire logic [3:0] short_det,
  input wire logic [11:0] class_result,
  output logic [3:0] port_power_en,
  output logic [3:0] inrush_limit_en,
  output logic [3:0] dual_slope_en,
  output logic [3:0] curve_double,
  output logic [3:0] gate_force_zero,
  output logic [3:0] hard_current_limit,
  output logic [11:0] overcurrent_cut_threshold,
  output logic alt_sense_resistor_sel,
  output logic irq
);
  localparam int N = pflt_pkg::NPORTS;

  //----------------------------------------------------------------
  // pin synchronisers
  //----------------------------------------------------------------
  logic [N-1:0] limit_s, pg_s, short_s;

  pflt_sync #(.W(N)) u_sync_lim (
    .pclk(pclk), .presetn(presetn), .async_in(limit_cmp),
    .sync_out(limit_s)
  );
  pflt_sync #(.W(N)) u_sync_pg (
    .pclk(pclk), .presetn(presetn), .async_in(power_good),
    .sync_out(pg_s)
  );
  pflt_sync #(.W(N)) u_sync_sc (
    .pclk(pclk), .presetn(presetn), .async_in(short_det),
    .sync_out(short_s)
  );

  //----------------------------------------------------------------
  // tick divider
  //----------------------------------------------------------------
  localparam logic [pflt_pkg::TICK_W-1:0] TICK_LAST =
    pflt_pkg::TICK_W'(pflt_pkg::TICK_CYCLES - 1);
  logic [pflt_pkg::TICK_W-1:0] div_q, div_d;
  logic tick;

  // one enable pulse every tick period
  always_comb begin
    tick = (div_q == TICK_LAST);
    div_d = tick ? '0 : pflt_pkg::TICK_W'(div_q + 1'b1);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end

  //----------------------------------------------------------------
  // register file
  //----------------------------------------------------------------
  logic [5:0] ctrl_q, ctrl_d;
  logic [3:0] curve_q, curve_d;
  logic [1:0] timing_q, timing_d;
  logic [11:0] cutcfg_q, cutcfg_d;
  logic [3:0] event_q, event_d;
  logic [3:0] mask_q, mask_d;
  logic [31:0] rdata_q, rdata_d;
  logic [3:0] expire;
  logic [pflt_pkg::TMR_W-1:0] tcount [N];
  logic [N-1:0] power_q, power_d;
  logic wr_en, setup, mapped;

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite;

  // address decode
  always_comb begin
    case (paddr)
      pflt_pkg::OFS_CTRL, pflt_pkg::OFS_CURVE, pflt_pkg::OFS_TIMING,
      pflt_pkg::OFS_CUTCFG, pflt_pkg::OFS_STATUS, pflt_pkg::OFS_EVENT,
      pflt_pkg::OFS_MASK, pflt_pkg::OFS_TMRVAL: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // read data is latched in the setup cycle so it comes from flops
  always_comb begin
    rdata_d = rdata_q;
    if (setup) begin
      case (paddr)
        pflt_pkg::OFS_CTRL: rdata_d = {26'h0, ctrl_q};
        pflt_pkg::OFS_CURVE: rdata_d = {28'h0, curve_q};
        pflt_pkg::OFS_TIMING: rdata_d = {30'h0, timing_q};
        pflt_pkg::OFS_CUTCFG: rdata_d = {20'h0, cutcfg_q};
        pflt_pkg::OFS_STATUS: rdata_d = {16'h0, short_s, pg_s,
                                         limit_s, power_q};
        pflt_pkg::OFS_EVENT: rdata_d = {28'h0, event_q};
        pflt_pkg::OFS_MASK: rdata_d = {28'h0, mask_q};
        pflt_pkg::OFS_TMRVAL: rdata_d = {tcount[3], tcount[2],
                                         tcount[1], tcount[0]};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // writes honour byte lane 0 and 1 strobes; fault flags are w1c
  always_comb begin
    ctrl_d = ctrl_q;
    curve_d = curve_q;
    timing_d = timing_q;
    cutcfg_d = cutcfg_q;
    mask_d = mask_q;
    event_d = event_q;
    if (wr_en && pstrb[0]) begin
      case (paddr)
        pflt_pkg::OFS_CTRL: ctrl_d = pwdata[5:0];
        pflt_pkg::OFS_CURVE: curve_d = pwdata[3:0];
        pflt_pkg::OFS_TIMING: timing_d = pwdata[1:0];
        pflt_pkg::OFS_CUTCFG: cutcfg_d[7:0] = pwdata[7:0];
        pflt_pkg::OFS_EVENT: event_d = event_q & ~pwdata[3:0];
        pflt_pkg::OFS_MASK: mask_d = pwdata[3:0];
        default: ctrl_d = ctrl_q;
      endcase
    end
    if (wr_en && pstrb[1] && paddr == pflt_pkg::OFS_CUTCFG) begin
      cutcfg_d[11:8] = pwdata[11:8];
    end
    // a fresh expiry beats a clear in the same cycle
    event_d = event_d | expire;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= pflt_pkg::CTRL_RST;
      curve_q <= pflt_pkg::CURVE_RST;
      timing_q <= pflt_pkg::TIMING_RST;
      cutcfg_q <= pflt_pkg::CUTCFG_RST;
      event_q <= pflt_pkg::EVENT_RST;
      mask_q <= pflt_pkg::MASK_RST;
      rdata_q <= 32'h0000_0000;
    end else begin
      ctrl_q <= ctrl_d;
      curve_q <= curve_d;
      timing_q <= timing_d;
      cutcfg_q <= cutcfg_d;
      event_q <= event_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
    end
  end

  // zero wait states; unmapped accesses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = rdata_q;
  assign irq = |(event_q & mask_q);
  assign alt_sense_resistor_sel = ctrl_q[pflt_pkg::CTRL_ALT_SENSE_BIT];

  //----------------------------------------------------------------
  // per-port power control and limit timers
  //----------------------------------------------------------------
  logic [N-1:0] lock_q, lock_d, turn_on;
  logic [N-1:0] hl_q, hl_d;
  logic [11:0] cut_q, cut_d;
  logic auto_mode;

  assign auto_mode = ctrl_q[pflt_pkg::CTRL_AUTO_BIT];

  generate
    for (genvar i = 0; i < N; i++) begin : g_port
      pflt_timer_if tif ();

      // a port refused after expiry until its enable is dropped
      always_comb begin
        turn_on[i] = ctrl_q[i] && !power_q[i] && !lock_q[i];
        power_d[i] = power_q[i];
        lock_d[i] = lock_q[i];
        hl_d[i] = hl_q[i];
        cut_d[3*i +: 3] = cut_q[3*i +: 3];
        if (!ctrl_q[i]) begin
          power_d[i] = 1'b0;
          lock_d[i] = 1'b0;
        end else if (expire[i]) begin
          power_d[i] = 1'b0;
          lock_d[i] = 1'b1;
        end else if (turn_on[i]) begin
          power_d[i] = 1'b1;
          // thresholds settle in the same edge that powers the port
          if (auto_mode) begin
            if (class_result[3*i +: 3] == pflt_pkg::CLASS_TYPE2) begin
              cut_d[3*i +: 3] = pflt_pkg::CUT_TYPE2;
              hl_d[i] = 1'b1;
            end else begin
              cut_d[3*i +: 3] = pflt_pkg::CUT_TYPE1;
              hl_d[i] = 1'b0;
            end
          end
        end
        // outside auto mode the host values pass straight through
        if (!auto_mode) begin
          cut_d[3*i +: 3] = cutcfg_q[3*i +: 3];
          hl_d[i] = curve_q[i];
        end
      end

      assign tif.tick = tick;
      assign tif.turn_on = turn_on[i];
      assign tif.powered = power_q[i];
      // a short always sits above the foldback threshold
      assign tif.limit = limit_s[i] || short_s[i];
      assign tif.setting = timing_q;
      assign expire[i] = tif.expire;
      assign tcount[i] = tif.count;

      pflt_limit_timer u_tmr (
        .pclk(pclk),
        .presetn(presetn),
        .tif(tif)
      );

      // inrush profile does not look at the curve select at all
      assign inrush_limit_en[i] = power_q[i] && !pg_s[i];
      assign dual_slope_en[i] = power_q[i] && pg_s[i];
      assign curve_double[i] = power_q[i] && pg_s[i] && hl_q[i];
      // gate pulled low on a short while foldback keeps regulating
      assign gate_force_zero[i] = power_q[i] && short_s[i];
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_q <= '0;
      lock_q <= '0;
      hl_q <= '0;
      cut_q <= '0;
    end else begin
      power_q <= power_d;
      lock_q <= lock_d;
      hl_q <= hl_d;
      cut_q <= cut_d;
    end
  end

  assign port_power_en = power_q;
  assign hard_current_limit = hl_q;
  assign overcurrent_cut_threshold = cut_q;
endmodule : pflt_top

// *** verification/pflt_host_model.sv ***
// host side apb master model for register traffic
`timescale 1ns/100ps
module pflt_host_model (
  input wire logic pclk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb
);
  // idle bus from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    pstrb = 4'h0;
  end
  // request is held until pready is seen at an edge; bounded wait
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e,
    output logic to);
    int n;
    to = 1'b1;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hF;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16 && to; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) begin
        q = prdata;
        e = pslverr;
        to = 1'b0;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : pflt_host_model

// *** verification/pflt_checker.sv ***
// port relations of the foldback supervisor
`timescale 1ns/100ps
module pflt_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] port_power_en,
  input wire logic [3:0] inrush_limit_en,
  input wire logic [3:0] dual_slope_en,
  input wire logic [3:0] curve_double,
  input wire logic [3:0] hard_current_limit,
  input wire logic [3:0] gate_force_zero,
  input wire logic alt_sense_resistor_sel,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic ctrl_wr;
  assign ctrl_wr = psel && penable && pwrite && paddr == 8'h00;
  profile_split_a: assert property (
    (inrush_limit_en | dual_slope_en) == port_power_en)
    else $error("inrush and foldback do not cover powered ports");
  dual_excl_a: assert property (
    (inrush_limit_en & dual_slope_en) == 4'h0)
    else $error("inrush and dual slope both active");
  curve_sel_a: assert property (
    curve_double == (dual_slope_en & hard_current_limit))
    else $error("double curve not tied to select");
  gate_zero_a: assert property (
    (gate_force_zero & ~port_power_en) == 4'h0)
    else $error("gate forced on an unpowered port");
  turn_on_a: assert property (
    $rose(port_power_en[0]) |-> $past(ctrl_wr && pwdata[0], 2))
    else $error("port powered without a control write");
  sense_hold_a: assert property (
    !$past(ctrl_wr) |-> $stable(alt_sense_resistor_sel))
    else $error("sense select moved without a write");
  zero_wait_a: assert property (
    psel && penable |-> pready)
    else $error("access phase without ready");
  unmapped_a: assert property (
    psel && penable && paddr > 8'h1C |-> pslverr)
    else $error("unmapped access not refused");
  cover property ($fell(port_power_en[0]));
  cover property ($rose(irq));
  cover property ($rose(curve_double[0]));
endmodule : pflt_checker

bind pflt_top pflt_checker u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .port_power_en,
  .inrush_limit_en, .dual_slope_en, .curve_double, .hard_current_limit,
  .gate_force_zero, .alt_sense_resistor_sel, .irq);

// *** verification/tb_top.sv ***
// self-checking bench for the foldback limit supervisor
`timescale 1ns/100ps
module tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready;
  logic pslverr, alt_sense_resistor_sel, irq, e, to;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] pstrb, limit_cmp, power_good, short_det, port_power_en;
  logic [3:0] inrush_limit_en, dual_slope_en, curve_double;
  logic [3:0] gate_force_zero, hard_current_limit;
  logic [11:0] class_result, overcurrent_cut_threshold;
  int num_errors = 0, n_checks = 0, n;
  always #10 pclk = ~pclk;
  pflt_host_model HOST (.pclk, .prdata, .pready, .pslverr, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb);
  pflt_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .limit_cmp,
    .power_good, .short_det, .class_result, .port_power_en,
    .inrush_limit_en, .dual_slope_en, .curve_double, .gate_force_zero,
    .hard_current_limit, .overcurrent_cut_threshold,
    .alt_sense_resistor_sel, .irq);
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] s, x);
    n_checks++;
    if (s !== x) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  // a hung bus ends the run at once
  task automatic acc(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    HOST.xfer(w, a, d, q, e, to);
    if (to) begin
      num_errors++;
      wrap_up();
    end
  endtask : acc
  task automatic hold(input int c);
    repeat (c) @(posedge pclk);
  endtask : hold
  // reset values, then a refused access
  task automatic t_regs;
    logic [7:0] ofs [6];
    ofs = '{pflt_pkg::OFS_CTRL, pflt_pkg::OFS_CURVE, pflt_pkg::OFS_TIMING,
      pflt_pkg::OFS_CUTCFG, pflt_pkg::OFS_EVENT, pflt_pkg::OFS_MASK};
    foreach (ofs[i]) begin
      acc(0, ofs[i], 0);
      chk("reset value", q, 0);
    end
    // idle ports hold the full count of the reset timeout setting
    acc(0, pflt_pkg::OFS_TMRVAL, 0);
    chk("timer reset", q, {4{pflt_pkg::LIMIT_TIMEOUT_SETTING_MAX0}});
    acc(0, 8'h20, 0);
    chk("unmapped err", {31'h0, e}, 1);
    $display("regs done");
  endtask : t_regs
  // inrush profile before power good, curve select after
  task automatic t_curve;
    acc(1, 8'h08, 1);
    acc(1, 8'h18, 1);
    acc(1, 8'h04, 5);
    acc(1, 8'h00, 32'h2F);
    hold(2);
    chk("alt sense", alt_sense_resistor_sel, 1);
    chk("inrush", inrush_limit_en, 4'hF);
    chk("no double", curve_double, 0);
    power_good <= 4'hF;
    hold(8);
    chk("dual slope", dual_slope_en, 4'hF);
    chk("double", curve_double, 4'h5);
    short_det <= 4'h4;
    hold(8);
    chk("gate zero", gate_force_zero, 4'h4);
    short_det <= 4'h0;
    $display("curve done");
  endtask : t_curve
  // limit held until the timer runs out
  task automatic t_expire;
    limit_cmp <= 4'h1;
    for (n = 0; n < 8000 && port_power_en[0] !== 1'b0; n++) hold(1);
    chk("expiry time", n > 6500 && n < 8000, 1);
    if (n >= 8000) wrap_up();
    limit_cmp <= 4'h0;
    hold(2);
    chk("irq", irq, 1);
    acc(0, 8'h14, 0);
    chk("fault flag", q, 1);
    acc(1, 8'h14, 1);
    hold(1);
    chk("irq clear", irq, 0);
    chk("locked off", port_power_en[0], 0);
    acc(1, 8'h00, 32'h2E);
    acc(1, 8'h00, 32'h2F);
    acc(0, 8'h1C, 0);
    chk("reload", q[7:0], 8'h0F);
    $display("expire done");
  endtask : t_expire
  // short limit episode, then slow recovery to the ceiling
  task automatic t_recover;
    limit_cmp <= 4'h2;
    hold(1500);
    limit_cmp <= 4'h0;
    acc(0, 8'h1C, 0);
    chk("count down", q[15:8] inside {8'h0C, 8'h0D}, 1);
    hold(10000);
    acc(0, 8'h1C, 0);
    chk("saturate", q[15:8], 8'h0F);
    $display("recover done");
  endtask : t_recover
  // auto mode derives limits from class
  task automatic t_auto;
    acc(1, 8'h00, 0);
    // host values on port 0 that auto mode must overwrite
    acc(1, 8'h0C, 32'h007);
    acc(1, 8'h00, 32'h19);
    hold(2);
    chk("auto cut", overcurrent_cut_threshold[11:9],
      pflt_pkg::CUT_TYPE2);
    chk("auto limit", hard_current_limit[3], 1);
    chk("auto cut t1", overcurrent_cut_threshold[2:0],
      pflt_pkg::CUT_TYPE1);
    chk("auto limit t1", hard_current_limit[0], 0);
    $display("auto done");
  endtask : t_auto
  initial begin
    {limit_cmp, power_good, short_det} = 12'h000;
    class_result = 12'h800;
    hold(4);
    presetn <= 1'b1;
    t_regs();
    t_curve();
    t_expire();
    t_recover();
    t_auto();
    wrap_up();
  end
endmodule : tb_top
